//--- verilog/isoc_ctrl.v
// Instruction-side memory controller: fetch path, register bus and tie-offs.
`timescale 1ns/1ns
`include "isoc_defines.vh"

module isoc_ctrl #(
  parameter GEN_NEWER = 1,
  parameter CLK_RATIO = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire fetch_req,
  input wire [0:29] fetch_addr,
  input wire [0:`ISOC_FETCH_W-1] fetch_read_data,
  input wire [0:`ISOC_DEBUG_W-1] debug_readback_data,
  input wire [0:`ISOC_TIE_W-1] control_tieoff,
  input wire [0:`ISOC_TIE_W-1] region_tieoff,
  input wire [0:`ISOC_BASE8_W-1] reg_base_addr_8b,
  input wire [0:`ISOC_BASE6_W-1] reg_base_addr_6b,
  input wire dcr_read,
  input wire dcr_write,
  input wire [0:`ISOC_ABUS_W-1] dcr_abus,
  input wire [0:31] dcr_wr_dbus,
  output reg [0:31] dcr_rd_dbus_reg,
  output reg dcr_ack_reg,
  output reg mem_en_reg,
  output reg [`ISOC_MADDR_MSB:`ISOC_MADDR_LSB] mem_rd_addr_reg,
  output reg [0:`ISOC_FETCH_W-1] fetch_data_reg,
  output reg fetch_valid_reg,
  output reg fetch_miss_reg,
  output reg [`ISOC_MADDR_MSB:`ISOC_MADDR_LSB] mem_wr_addr_reg,
  output reg [0:31] mem_wr_data_reg,
  output reg mem_even_we_reg,
  output reg mem_odd_we_reg,
  output reg [0:`ISOC_TIE_W-1] ctrl_bits_reg,
  output reg ratio_ok_reg
);

  // ========================================================================
  // State codes for the register-bus slave
  // ========================================================================
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RDWAIT = 2'h1;
  localparam [1:0] ST_ACK = 2'h2;

  // The controller and its memory share clk_sys, the memory clock.
  // The ratio to the processor clock is fixed at build time and checked here.
  localparam RATIO_MAX = GEN_NEWER ? `ISOC_RATIO_MAX_NEW : `ISOC_RATIO_MAX_OLD;
  localparam RATIO_GOOD = (CLK_RATIO >= `ISOC_RATIO_MIN) && (CLK_RATIO <= RATIO_MAX);

  // ========================================================================
  // Synchronisers for inputs from the processor domain and tie pins
  // ========================================================================
  wire [0:`ISOC_TIE_W-1] ctl_tie_s;
  wire [0:`ISOC_TIE_W-1] reg_tie_s;
  wire [0:`ISOC_BASE8_W-1] base8_s;
  wire [0:`ISOC_BASE6_W-1] base6_s;
  wire rd_s;
  wire wr_s;
  wire [0:`ISOC_ABUS_W-1] abus_s;
  wire [0:31] wdata_s;

  // The tie-off synchronisers keep running through reset, so the reset
  // branch below copies the live tie values and not cleared flops.
  isoc_sync #(.W(`ISOC_TIE_W)) u_sync_ctl (
    .clk_sys(clk_sys),
    .rst_n(1'b1),
    .async_in(control_tieoff),
    .sync_out(ctl_tie_s)
  );

  isoc_sync #(.W(`ISOC_TIE_W)) u_sync_reg (
    .clk_sys(clk_sys),
    .rst_n(1'b1),
    .async_in(region_tieoff),
    .sync_out(reg_tie_s)
  );

  isoc_sync #(.W(`ISOC_BASE8_W)) u_sync_b8 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(reg_base_addr_8b),
    .sync_out(base8_s)
  );

  isoc_sync #(.W(`ISOC_BASE6_W)) u_sync_b6 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(reg_base_addr_6b),
    .sync_out(base6_s)
  );

  // Address and data are held by the master for the whole access, so a
  // plain two-flop path is safe once the synchronised strobe is seen.
  isoc_sync #(.W(2 + `ISOC_ABUS_W + 32)) u_sync_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({dcr_read, dcr_write, dcr_abus, dcr_wr_dbus}),
    .sync_out({rd_s, wr_s, abus_s, wdata_s})
  );

  // ========================================================================
  // Register file
  // ========================================================================
  reg [0:31] init_address_reg;
  reg [0:31] init_address_next;
  reg [0:31] fill_data_reg;
  reg [0:31] fill_data_next;
  reg [0:31] region_select_reg;
  reg [0:31] region_select_next;
  reg [0:31] controller_control_reg;
  reg [0:31] controller_control_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] wait_reg;
  reg [1:0] wait_next;
  reg [0:31] rd_dbus_next;
  reg ack_next;
  reg even_we_next;
  reg odd_we_next;
  reg [`ISOC_MADDR_MSB:`ISOC_MADDR_LSB] wr_addr_next;
  reg [0:31] wr_data_next;

  // ========================================================================
  // Address decode
  // ========================================================================
  reg addr_hit;
  reg [1:0] addr_sel;

  always @* begin
    addr_sel = abus_s[`ISOC_ABUS_W-2:`ISOC_ABUS_W-1];
    if (GEN_NEWER != 0) begin
      // Only the four lowest offsets under the base belong to this block.
      addr_hit = (abus_s[0:5] == base6_s) && (abus_s[6:7] == 2'h0);
    end else begin
      addr_hit = (abus_s[0:7] == base8_s);
    end
  end

  wire req_any = rd_s | wr_s;
  wire [0:31] init_word = init_address_reg;

  // ========================================================================
  // Register-bus slave
  // ========================================================================
  always @* begin
    state_next = state_reg;
    wait_next = wait_reg;
    ack_next = dcr_ack_reg;
    rd_dbus_next = dcr_rd_dbus_reg;
    init_address_next = init_address_reg;
    fill_data_next = fill_data_reg;
    region_select_next = region_select_reg;
    controller_control_next = controller_control_reg;
    even_we_next = 1'b0;
    odd_we_next = 1'b0;
    wr_addr_next = init_word[`ISOC_MADDR_MSB:`ISOC_MADDR_LSB];
    wr_data_next = fill_data_reg;
    case (state_reg)
      ST_IDLE: begin
        ack_next = 1'b0;
        if (req_any && addr_hit) begin
          if (wr_s) begin
            // Stored only on a write; reset loads the tie-offs into the region and control registers.
            case (addr_sel)
              `ISOC_SEL_INIT: init_address_next = wdata_s;
              `ISOC_SEL_FILL: begin
                fill_data_next = wdata_s;
                // Writing fill data places it at the init address.
                wr_data_next = wdata_s;
                if (init_word[`ISOC_WORD_SEL_BIT]) begin
                  odd_we_next = 1'b1;
                end else begin
                  even_we_next = 1'b1;
                end
              end
              `ISOC_SEL_REGION: region_select_next = wdata_s;
              default: controller_control_next = wdata_s;
            endcase
            ack_next = 1'b1;
            state_next = ST_ACK;
          end else if (addr_sel == `ISOC_SEL_FILL) begin
            // The read-back memory needs the address presented first.
            wait_next = `ISOC_RD_WAIT;
            state_next = ST_RDWAIT;
          end else begin
            case (addr_sel)
              `ISOC_SEL_INIT: rd_dbus_next = init_address_reg;
              `ISOC_SEL_REGION: rd_dbus_next = region_select_reg;
              default: rd_dbus_next = controller_control_reg;
            endcase
            ack_next = 1'b1;
            state_next = ST_ACK;
          end
        end
      end
      ST_RDWAIT: begin
        wait_next = wait_reg - 2'h1;
        if (wait_reg == 2'h1) begin
          rd_dbus_next = debug_readback_data;
          ack_next = 1'b1;
          state_next = ST_ACK;
        end
      end
      ST_ACK: begin
        // Hold the answer until the master drops its strobe.
        if (!req_any) begin
          ack_next = 1'b0;
          rd_dbus_next = `ISOC_RST_WORD;
          state_next = ST_IDLE;
        end
      end
      default: begin
        ack_next = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      wait_reg <= 2'h0;
      dcr_ack_reg <= 1'b0;
      dcr_rd_dbus_reg <= `ISOC_RST_WORD;
      init_address_reg <= `ISOC_RST_WORD;
      fill_data_reg <= `ISOC_RST_WORD;
      // Reset copies the tie-offs into the top byte of the region and control registers.
      region_select_reg <= {reg_tie_s, 24'h000000};
      controller_control_reg <= {ctl_tie_s, 24'h000000};
      mem_even_we_reg <= 1'b0;
      mem_odd_we_reg <= 1'b0;
      mem_wr_addr_reg <= 21'h000000;
      mem_wr_data_reg <= `ISOC_RST_WORD;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      dcr_ack_reg <= ack_next;
      dcr_rd_dbus_reg <= rd_dbus_next;
      init_address_reg <= init_address_next;
      fill_data_reg <= fill_data_next;
      region_select_reg <= region_select_next;
      controller_control_reg <= controller_control_next;
      mem_even_we_reg <= even_we_next;
      mem_odd_we_reg <= odd_we_next;
      mem_wr_addr_reg <= wr_addr_next;
      mem_wr_data_reg <= wr_data_next;
    end
  end

  // ========================================================================
  // Instruction fetch path
  // ========================================================================
  reg fetch_pend_reg;
  // The live register is compared, so a new region applies to the next fetch.
  wire region_match = (fetch_addr[`ISOC_REGION_MSB:`ISOC_REGION_LSB] ==
                       region_select_reg[0:7]);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_en_reg <= 1'b0;
      mem_rd_addr_reg <= 21'h000000;
      fetch_pend_reg <= 1'b0;
      fetch_valid_reg <= 1'b0;
      fetch_miss_reg <= 1'b0;
      fetch_data_reg <= 64'h0000_0000_0000_0000;
      ctrl_bits_reg <= 8'h00;
      ratio_ok_reg <= 1'b0;
    end else begin
      mem_en_reg <= fetch_req && region_match;
      fetch_miss_reg <= fetch_req && !region_match;
      if (fetch_req && region_match) begin
        mem_rd_addr_reg <= fetch_addr[`ISOC_MADDR_MSB:`ISOC_MADDR_LSB];
      end
      fetch_pend_reg <= mem_en_reg;
      fetch_valid_reg <= fetch_pend_reg;
      if (fetch_pend_reg) begin
        fetch_data_reg <= fetch_read_data;
      end
      ctrl_bits_reg <= controller_control_reg[0:7];
      ratio_ok_reg <= RATIO_GOOD;
    end
  end

endmodule // isoc_ctrl

//--- verilog/isoc_defines.vh
// Constants shared by the instruction-side memory controller files.
`ifndef ISOC_DEFINES_VH
`define ISOC_DEFINES_VH

// ==========================================================================
// Register selection by the two low register-bus address bits
// ==========================================================================
`define ISOC_SEL_INIT 2'h0
`define ISOC_SEL_FILL 2'h1
`define ISOC_SEL_REGION 2'h2
`define ISOC_SEL_CTRL 2'h3

// Addresses that result from a 6-bit base of 6'h01.
`define ISOC_OFS_INIT 10'h010
`define ISOC_OFS_FILL 10'h011
`define ISOC_OFS_REGION 10'h012
`define ISOC_OFS_CTRL 10'h013

// ==========================================================================
// Widths and field positions (bit 0 is the most significant bit)
// ==========================================================================
`define ISOC_ABUS_W 10
`define ISOC_BASE8_W 8
`define ISOC_BASE6_W 6
`define ISOC_TIE_W 8
`define ISOC_FETCH_W 64
`define ISOC_DEBUG_W 32
`define ISOC_REGION_MSB 0
`define ISOC_REGION_LSB 7
`define ISOC_MADDR_MSB 8
`define ISOC_MADDR_LSB 28
`define ISOC_WORD_SEL_BIT 29

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define ISOC_RST_WORD 32'h0000_0000
`define ISOC_RATIO_MIN 1
`define ISOC_RATIO_MAX_NEW 8
`define ISOC_RATIO_MAX_OLD 4
`define ISOC_RD_WAIT 2'h2

`endif

//--- verilog/isoc_sync.v
// Two-flop synchroniser for a bus of slow or quasi-static inputs.
`timescale 1ns/1ns
module isoc_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] stage1_reg;

  // The first stage feeds only the second stage.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule // isoc_sync

//--- tb/isoc_ctrl_assertions.sv
// Port checker for the instruction-side memory controller.
`timescale 1ns/1ns
module isoc_ctrl_assertions #(
  parameter GEN_NEWER = 1,
  parameter CLK_RATIO = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire fetch_req,
  input wire [0:29] fetch_addr,
  input wire [0:63] fetch_read_data,
  input wire dcr_read,
  input wire dcr_write,
  input wire dcr_ack_reg,
  input wire [0:31] dcr_rd_dbus_reg,
  input wire mem_en_reg,
  input wire [8:28] mem_rd_addr_reg,
  input wire [0:63] fetch_data_reg,
  input wire fetch_valid_reg,
  input wire fetch_miss_reg,
  input wire mem_even_we_reg,
  input wire mem_odd_we_reg,
  input wire ratio_ok_reg
);
  wire strobe = dcr_read | dcr_write;
  wire [8:28] want = fetch_addr[8:28];
  wire ratio_fits = CLK_RATIO >= 1 && CLK_RATIO <= (GEN_NEWER ? 8 : 4);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence hit_s;
    fetch_req ##1 mem_en_reg;
  endsequence
  // Four idle samples cover the two synchroniser flops plus the clearing edge.
  sequence idle_s;
    !strobe [*4];
  endsequence
  // ==========================================================================
  // Fetch path
  hit_or_miss_a: assert property (fetch_req |=> mem_en_reg ^ fetch_miss_reg)
    else $error("fetch neither hit nor miss");
  en_cause_a: assert property (mem_en_reg |-> $past(fetch_req))
    else $error("enable without request");
  rd_addr_a: assert property (hit_s |-> mem_rd_addr_reg == $past(want))
    else $error("wrong read address");
  valid_lat_a: assert property (hit_s |-> ##2 fetch_valid_reg)
    else $error("fetch data late");
  data_cap_a: assert property (fetch_valid_reg |->
    fetch_data_reg == $past(fetch_read_data) && $past(mem_en_reg, 2)) else $error("bad fetch data");
  // ==========================================================================
  // Register bus and clock-ratio flag
  we_cause_a: assert property ((mem_even_we_reg || mem_odd_we_reg) |-> $rose(dcr_ack_reg))
    else $error("memory write without bus write");
  ack_cause_a: assert property ($rose(dcr_ack_reg) |-> $past(strobe, 3))
    else $error("ack without strobe");
  ack_drop_a: assert property (idle_s |-> !dcr_ack_reg)
    else $error("ack stuck");
  rd_idle_a: assert property (!dcr_ack_reg |-> dcr_rd_dbus_reg == 32'h0)
    else $error("read data while idle");
  ratio_ok_a: assert property ($past(rst_n) |-> ratio_ok_reg == ratio_fits)
    else $error("ratio flag wrong");
endmodule // isoc_ctrl_assertions

bind isoc_ctrl isoc_ctrl_assertions #(.GEN_NEWER(GEN_NEWER), .CLK_RATIO(CLK_RATIO)) u_chk (
  .clk_sys, .rst_n, .fetch_req, .fetch_addr, .fetch_read_data, .dcr_read, .dcr_write,
  .dcr_ack_reg, .dcr_rd_dbus_reg, .mem_en_reg, .mem_rd_addr_reg, .fetch_data_reg,
  .fetch_valid_reg, .fetch_miss_reg, .mem_even_we_reg, .mem_odd_we_reg, .ratio_ok_reg);

//--- tb/isoc_bram_model.sv
// Behavioural instruction memory behind the controller.
`timescale 1ns/1ns
module isoc_bram_model (
  input wire clk_sys,
  input wire mem_en_reg,
  input wire [8:28] mem_rd_addr_reg,
  input wire [8:28] mem_wr_addr_reg,
  input wire [0:31] mem_wr_data_reg,
  input wire mem_even_we_reg,
  output reg [0:63] fetch_read_data,
  output reg [0:31] debug_readback_data
);
  reg [0:31] even_mem [0:31];
  integer k;
  // Cleared so that a read-back before any fill write returns a known word.
  initial for (k = 0; k < 32; k = k + 1) even_mem[k] = 32'h0;
  initial fetch_read_data = 64'h0;
  initial debug_readback_data = 32'h0;
  // Data toggles when no fetch is answered, so a late sample never sees a stale word.
  always @(posedge clk_sys) begin
    if (mem_en_reg) begin
      fetch_read_data <= {2{11'h5a5, mem_rd_addr_reg}};
    end else begin
      fetch_read_data <= ~fetch_read_data;
    end
    if (mem_even_we_reg) begin
      even_mem[mem_wr_addr_reg[24:28]] <= mem_wr_data_reg;
    end
    debug_readback_data <= even_mem[mem_wr_addr_reg[24:28]];
  end
endmodule // isoc_bram_model

//--- tb/isoc_ctrl_tb.sv
// Self-checking bench for the instruction-side memory controller.
`timescale 1ns/1ns
module isoc_ctrl_tb;
  reg clk_sys, rst_n, fetch_req, dcr_read, dcr_write;
  reg [0:29] fetch_addr;
  reg [0:7] control_tieoff, region_tieoff, region_new;
  reg [0:5] reg_base_addr_6b;
  reg [0:9] dcr_abus;
  reg [0:31] dcr_wr_dbus, r, v, d;
  wire [0:63] fetch_read_data, fetch_data_reg;
  wire [0:31] debug_readback_data, dcr_rd_dbus_reg, mem_wr_data_reg;
  wire [8:28] mem_rd_addr_reg, mem_wr_addr_reg;
  wire [0:7] ctrl_bits_reg;
  wire dcr_ack_reg, mem_en_reg, fetch_valid_reg, fetch_miss_reg;
  wire mem_even_we_reg, mem_odd_we_reg, ratio_ok_reg;
  reg ack_q = 0, rd_busy = 0;
  integer err_count = 0, check_count = 0, miss_seen = 0, miss_exp = 0, i;
  integer we_even = 0, we_odd = 0;
  reg [0:63] fq[$];
  reg [0:31] rq[$];

  isoc_ctrl i_dut (.clk_sys, .rst_n, .fetch_req, .fetch_addr, .fetch_read_data,
    .debug_readback_data, .control_tieoff, .region_tieoff, .reg_base_addr_8b(8'h00),
    .reg_base_addr_6b, .dcr_read, .dcr_write, .dcr_abus, .dcr_wr_dbus, .dcr_rd_dbus_reg,
    .dcr_ack_reg, .mem_en_reg, .mem_rd_addr_reg, .fetch_data_reg, .fetch_valid_reg,
    .fetch_miss_reg, .mem_wr_addr_reg, .mem_wr_data_reg, .mem_even_we_reg,
    .mem_odd_we_reg, .ctrl_bits_reg, .ratio_ok_reg);
  isoc_bram_model i_mem (.clk_sys, .mem_en_reg, .mem_rd_addr_reg, .mem_wr_addr_reg,
    .mem_wr_data_reg, .mem_even_we_reg, .fetch_read_data, .debug_readback_data);

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task chk(input string what, input [0:63] seen, input [0:63] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // ==========================================================================
  // Bus and fetch drivers
  // A miss address keeps the base but sets a low bit that no register uses.
  task dcr(input rd, input [0:1] sel, input [0:31] dat, input hit);
    integer n;
    begin
      if (rd && hit) rq.push_back(dat);
      rd_busy = rd && hit;
      dcr_abus = {reg_base_addr_6b, (hit ? 2'b00 : 2'b01), sel};
      dcr_wr_dbus = rd ? ~dat : dat;
      dcr_read = rd;
      dcr_write = !rd;
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end while (dcr_ack_reg !== 1'b1 && n < 12);
      chk("ack", dcr_ack_reg, hit);
      dcr_read = 0;
      dcr_write = 0;
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end while (dcr_ack_reg !== 1'b0 && n < 12);
      chk("ack drop", dcr_ack_reg, 0);
      rd_busy = 0;
    end
  endtask

  task fetch(input [0:7] top, input hit);
    begin
      r = $urandom;
      fetch_addr = {top, r[10:31]};
      fetch_req = 1;
      if (hit) fq.push_back({2{11'h5a5, fetch_addr[8:28]}});
      else miss_exp = miss_exp + 1;
      @(posedge clk_sys);
      #1;
    end
  endtask

  // ==========================================================================
  // Result monitor
  always @(posedge clk_sys) begin
    ack_q <= dcr_ack_reg;
    if (dcr_ack_reg && !ack_q && rd_busy) begin
      if (rq.size() == 0) chk("read queue", 0, 1);
      else chk("read", dcr_rd_dbus_reg, rq.pop_front());
    end
    if (fetch_valid_reg) begin
      if (fq.size() == 0) chk("fetch queue", 0, 1);
      else chk("fetch", fetch_data_reg, fq.pop_front());
    end
    if (fetch_miss_reg) miss_seen = miss_seen + 1;
    if (mem_even_we_reg) we_even = we_even + 1;
    if (mem_odd_we_reg) we_odd = we_odd + 1;
  end

  initial begin
    #100000;
    err_count = err_count + 1;
    results;
  end

  initial begin
    rst_n = 0;
    fetch_req = 0;
    dcr_read = 0;
    dcr_write = 0;
    fetch_addr = 0;
    dcr_abus = 0;
    dcr_wr_dbus = 0;
    i = $urandom(89193);
    control_tieoff = $urandom;
    region_tieoff = $urandom;
    region_new = ~region_tieoff;
    reg_base_addr_6b = $urandom;
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1;
    dcr(1, 0, 0, 1);
    dcr(1, 1, 0, 1);
    dcr(1, 2, {region_tieoff, 24'h0}, 1);
    dcr(1, 3, {control_tieoff, 24'h0}, 1);
    chk("ctrl bits", ctrl_bits_reg, control_tieoff);
    chk("ratio", ratio_ok_reg, 1);
    for (i = 0; i < 8; i = i + 1) fetch(region_tieoff, 1);
    fetch(region_new, 0);
    fetch(region_tieoff, 1);
    fetch_req = 0;
    dcr(0, 2, {region_new, 24'h0}, 1);
    fetch(region_new, 1);
    fetch(region_tieoff, 0);
    fetch_req = 0;
    d = $urandom;
    dcr(0, 3, d, 1);
    dcr(1, 3, d, 1);
    chk("ctrl bits", ctrl_bits_reg, d[0:7]);
    dcr(0, 2, 0, 0);
    dcr(1, 2, {region_new, 24'h0}, 1);
    v = $urandom & 32'hffff_fffb;
    d = $urandom;
    dcr(0, 0, v, 1);
    dcr(0, 1, d, 1);
    chk("fill out", mem_wr_data_reg, d);
    dcr(1, 0, v, 1);
    dcr(1, 1, d, 1);
    dcr(0, 0, v | 32'h0000_0004, 1);
    dcr(0, 1, ~d, 1);
    rst_n = 0;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1;
    dcr(1, 2, {region_tieoff, 24'h0}, 1);
    fetch(region_tieoff, 1);
    fetch_req = 0;
    repeat (6) @(posedge clk_sys);
    chk("misses", miss_seen, miss_exp);
    chk("even we", we_even, 1);
    chk("odd we", we_odd, 1);
    chk("pending", fq.size() + rq.size(), 0);
    results;
  end
endmodule // isoc_ctrl_tb
